// ==== core/dsem_event_map.sv ====
`timescale 1ns/100ps
`default_nettype none
module dsem_event_map
  import dsem_pkg::*;
(
  // Clock, reset, enable.
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      clk_en_in,
  // Peripheral event pulses from the core clock domain.
  input  wire logic                      host_irq_event_in,
  input  wire logic                      timer0_event_in,
  input  wire logic                      timer1_event_in,
  input  wire logic                      timer2_event_in,
  input  wire logic                      sdram_refresh_event_in,
  input  wire logic                      serial0_tx_event_in,
  input  wire logic                      serial0_rx_event_in,
  input  wire logic                      serial1_tx_event_in,
  input  wire logic                      serial1_rx_event_in,
  // Pin events; 4 to 7 are the external irq pins, asynchronous levels.
  input  wire logic [dsem_pkg::NUM_PIN_EVT-1:0] pin_event_in,
  // Completion chaining events, one per channel.
  input  wire logic [dsem_pkg::NUM_CH-1:0]      chain_event_in,
  // Control from the transfer controller.
  input  wire logic [dsem_pkg::NUM_CH-1:0]      event_enable_in,
  input  wire logic [dsem_pkg::NUM_CH-1:0]      event_clear_in,
  input  wire logic [dsem_pkg::NUM_CH-1:0]      xfer_start_in,
  input  wire logic [dsem_pkg::NUM_CH*dsem_pkg::PRIO_W-1:0] param_prio_in,
  // Captured events and requests.
  output logic      [31:0]               event_capture_low_out,
  output logic      [31:0]               event_capture_high_out,
  output logic      [dsem_pkg::NUM_CH-1:0]      xfer_req_out,
  output logic      [dsem_pkg::NUM_CH*dsem_pkg::PRIO_W-1:0] req_prio_out
);
  import dsem_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_PIN_EVT-1:0] pin_sync;
  logic [NUM_PIN_EVT-1:0] pin_prev_q;
  logic [NUM_PIN_EVT-1:0] pin_prev_d;
  logic [NUM_PIN_EVT-1:0] pin_rise;

  // Pins are asynchronous, so they are synchronised before edge detection.
  dsem_sync2 #(.W(NUM_PIN_EVT)) u_pin_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .clk_en_in   (clk_en_in),
    .async_in    (pin_event_in),
    .sync_out    (pin_sync)
  );

  // A pin event therefore reaches its capture bit three edges after the pin rises.
  always_comb begin
    pin_prev_d = clk_en_in ? pin_sync : pin_prev_q;
    pin_rise   = pin_sync & ~pin_prev_q;
  end

  // The history resets to the idle pin level, so leaving reset makes no false edge.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin_prev_q <= '0;
    end else begin
      pin_prev_q <= pin_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_CH-1:0] periph_evt;
  logic [NUM_CH-1:0] any_evt;

  // Fixed wiring; unassigned channels stay zero.
  always_comb begin
    periph_evt = '0;
    periph_evt[CH_HOST_IRQ]  = host_irq_event_in;
    periph_evt[CH_TIMER0]    = timer0_event_in;
    periph_evt[CH_TIMER1]    = timer1_event_in;
    periph_evt[CH_SDRAM_REF] = sdram_refresh_event_in;
    periph_evt[CH_TIMER2]    = timer2_event_in;
    periph_evt[CH_SER0_TX]   = serial0_tx_event_in;
    periph_evt[CH_SER0_RX]   = serial0_rx_event_in;
    periph_evt[CH_SER1_TX]   = serial1_tx_event_in;
    periph_evt[CH_SER1_RX]   = serial1_rx_event_in;
    periph_evt[CH_PIN4 +: 4] = pin_rise[7:4];
    periph_evt[CH_PIN0 +: 4] = pin_rise[3:0];
    periph_evt[CH_PIN8 +: 8] = pin_rise[15:8];
    any_evt = periph_evt | chain_event_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_CH-1:0] capture_q;
  logic [NUM_CH-1:0] capture_d;

  // A new event beats a clear in the same cycle so the clear never drops it.
  // Start and clear share one path: both mean the pending event has been dealt with.
  always_comb begin
    capture_d = capture_q;
    if (clk_en_in) begin
      capture_d = (capture_q & ~(event_clear_in | xfer_start_in)) | any_evt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      capture_q <= CAPTURE_RST;
    end else begin
      capture_q <= capture_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_CH*PRIO_W-1:0] prio_q;
  logic [NUM_CH*PRIO_W-1:0] prio_d;

  // Priority is latched per channel, independent of every other channel.
  always_comb begin
    prio_d = clk_en_in ? param_prio_in : prio_q;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      prio_q <= '0;
    end else begin
      prio_q <= prio_d;
    end
  end

  assign event_capture_low_out  = capture_q[31:0];
  assign event_capture_high_out = capture_q[63:32];
  // Disabled channels keep their capture bit but raise no request.
  assign xfer_req_out           = capture_q & event_enable_in;
  assign req_prio_out           = prio_q;

  ////////////////////////////////////////////////////////////////////////////
  // Routing: every event lands on its own channel and nowhere else.
  a_every_channel: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in |=> (capture_q & $past(any_evt)) == $past(any_evt))
    else $error("event lost on its own channel");
  a_fixed_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && !timer0_event_in && !chain_event_in[CH_TIMER0] && !capture_q[CH_TIMER0]
    |=> !capture_q[CH_TIMER0])
    else $error("channel 1 set without its own event");
  a_host_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && host_irq_event_in |=> capture_q[CH_HOST_IRQ])
    else $error("host event not on channel 0");
  a_timer1_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && timer1_event_in |=> capture_q[CH_TIMER1])
    else $error("timer 1 event not on channel 2");
  a_capture_on_event: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && timer2_event_in |=> capture_q[CH_TIMER2])
    else $error("timer 2 event not captured");
  a_gp_low_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && pin_rise[2] |=> capture_q[CH_PIN0 + 2])
    else $error("pin event 2 not on channel 10");
  a_gp_high_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && pin_rise[12] |=> capture_q[CH_PIN8 + 4])
    else $error("pin event 12 not on channel 52");
  a_sdram_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && sdram_refresh_event_in |=> capture_q[CH_SDRAM_REF])
    else $error("refresh event not on channel 3");
  a_pin_to_ch: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && pin_rise[5] |=> capture_q[5])
    else $error("pin event 5 not on channel 5");
  a_pin_ext_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && pin_rise[7] |=> capture_q[CH_PIN4 + 3])
    else $error("pin event 7 not on channel 7");
  a_no_fall: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && !pin_rise[6] && !chain_event_in[6] && !capture_q[6] |=> !capture_q[6])
    else $error("channel 6 set without a rising pin");
  a_ser0_tx_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && serial0_tx_event_in |=> capture_q[CH_SER0_TX])
    else $error("serial 0 transmit event misrouted");
  a_ser1_tx_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && serial1_tx_event_in |=> capture_q[CH_SER1_TX])
    else $error("serial 1 transmit event misrouted");
  a_serial_map: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && serial1_rx_event_in |=> capture_q[CH_SER1_RX])
    else $error("serial rx event misrouted");
  a_unmapped_quiet: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && !chain_event_in[20] && !capture_q[20] |=> !capture_q[20])
    else $error("unmapped channel captured");
  a_chain_any: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && chain_event_in[63] |=> capture_q[63])
    else $error("chain event not captured");

  // Capture and release.
  a_capture_disabled: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && sdram_refresh_event_in && !event_enable_in[CH_SDRAM_REF]
    |=> capture_q[CH_SDRAM_REF])
    else $error("disabled channel lost event");
  a_req_enable: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && chain_event_in[0] |=> xfer_req_out[0] == event_enable_in[0])
    else $error("request does not follow enable");
  a_capture_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    capture_q[1] && !event_clear_in[1] && !xfer_start_in[1] |=> capture_q[1])
    else $error("capture bit dropped");
  a_capture_clear: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && xfer_start_in[0] && !any_evt[0] |=> !capture_q[0])
    else $error("serviced bit not cleared");
  a_set_wins: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && any_evt[1] && event_clear_in[1] |=> capture_q[1])
    else $error("clear beat a same-cycle event");
  a_frozen_capture: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !clk_en_in |=> capture_q == $past(capture_q))
    else $error("capture moved while frozen");

  // Priority.
  a_prio_follow: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in |=> req_prio_out == $past(param_prio_in))
    else $error("priority not taken");
  a_prio_frozen: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !clk_en_in |=> req_prio_out == $past(req_prio_out))
    else $error("priority moved while frozen");

  // Main scenarios.
  c_capture_disabled: cover property (@(posedge core_clk_in) disable iff (rst_in)
    capture_q[3] && !event_enable_in[3]);
  c_chain_trigger: cover property (@(posedge core_clk_in) disable iff (rst_in)
    chain_event_in[40] ##1 capture_q[40]);
  c_set_and_clear: cover property (@(posedge core_clk_in) disable iff (rst_in)
    any_evt[1] && event_clear_in[1]);
  c_pin_event: cover property (@(posedge core_clk_in) disable iff (rst_in)
    pin_rise[12] ##1 capture_q[CH_PIN8 + 4]);
  c_frozen_event: cover property (@(posedge core_clk_in) disable iff (rst_in)
    !clk_en_in && chain_event_in[30]);
endmodule
`default_nettype wire

// ==== core/dsem_sync2.sv ====
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for a vector of asynchronous inputs.
module dsem_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  input  wire logic         clk_en_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = clk_en_in ? async_in : meta_q;
    sync_d = clk_en_in ? meta_q : sync_q;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ==== inc/dsem_pkg.sv ====
package dsem_pkg;
  localparam int unsigned NUM_CH      = 64;
  localparam int unsigned PRIO_W      = 3;
  localparam int unsigned NUM_PIN_EVT = 16;
  // Channel assignments for the fixed event sources.
  localparam int unsigned CH_HOST_IRQ  = 0;
  localparam int unsigned CH_TIMER0    = 1;
  localparam int unsigned CH_TIMER1    = 2;
  localparam int unsigned CH_SDRAM_REF = 3;
  localparam int unsigned CH_PIN4      = 4;
  localparam int unsigned CH_PIN0      = 8;
  localparam int unsigned CH_SER0_TX   = 12;
  localparam int unsigned CH_SER0_RX   = 13;
  localparam int unsigned CH_SER1_TX   = 14;
  localparam int unsigned CH_SER1_RX   = 15;
  localparam int unsigned CH_TIMER2    = 19;
  localparam int unsigned CH_PIN8      = 48;
  localparam logic [63:0] CAPTURE_RST  = 64'h0000_0000_0000_0000;
  localparam logic [63:0] ENABLE_RST   = 64'h0000_0000_0000_0000;
endpackage

// ==== verif/dsem_event_map_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module dsem_event_map_bench;
  import dsem_pkg::*;
  logic         clk;
  logic         rst;
  logic [8:0]   fire;
  logic [8:0]   evt;
  logic [15:0]  lvl;
  logic [15:0]  pin;
  logic [63:0]  chain;
  logic [63:0]  en;
  logic [63:0]  clr;
  logic [63:0]  start;
  logic [191:0] prio;
  logic [191:0] prio_o;
  logic [31:0]  cap_lo;
  logic [31:0]  cap_hi;
  logic [63:0]  req;
  logic [63:0]  cap;
  logic         clk_en;
  int           n_mismatch;
  int           comparisons;
  int           ch[9] = '{CH_HOST_IRQ, CH_TIMER0, CH_TIMER1, CH_SDRAM_REF, CH_SER0_TX,
                          CH_SER0_RX, CH_SER1_TX, CH_SER1_RX, CH_TIMER2};
  assign cap = {cap_hi, cap_lo};
  dsem_evt_src src (.core_clk_in(clk), .fire_in(fire), .pin_lvl_in(lvl), .evt_out(evt),
                    .pin_out(pin));
  dsem_event_map dut (.core_clk_in(clk), .rst_in(rst), .clk_en_in(clk_en),
    .host_irq_event_in(evt[0]), .timer0_event_in(evt[1]), .timer1_event_in(evt[2]),
    .sdram_refresh_event_in(evt[3]), .serial0_tx_event_in(evt[4]),
    .serial0_rx_event_in(evt[5]), .serial1_tx_event_in(evt[6]),
    .serial1_rx_event_in(evt[7]), .timer2_event_in(evt[8]), .pin_event_in(pin),
    .chain_event_in(chain), .event_enable_in(en), .event_clear_in(clr),
    .xfer_start_in(start), .param_prio_in(prio), .event_capture_low_out(cap_lo),
    .event_capture_high_out(cap_hi), .xfer_req_out(req), .req_prio_out(prio_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report(input logic ok, input logic [191:0] got, input logic [191:0] exp);
    comparisons++;
    if (!ok) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_cap(input logic [63:0] got, input logic [63:0] exp);
    report(got === exp, {128'h0, got}, {128'h0, exp});
  endtask
  task automatic cmp_req(input logic [63:0] got, input logic [63:0] exp);
    report(got === exp, {128'h0, got}, {128'h0, exp});
  endtask
  task automatic cmp_prio(input logic [191:0] got, input logic [191:0] exp);
    report(got === exp, got, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic clear_all;
    clr = '1;
    tick(1);
    clr = '0;
    tick(1);
  endtask
  // Enables stay low so every capture below happens on a disabled channel.
  task automatic t_core;
    for (int i = 0; i < 9; i++) begin
      fire = 9'h001 << i;
      tick(1);
      fire = 9'h000;
      tick(1);
      cmp_cap(cap, 64'h1 << ch[i]);
      clear_all();
    end
  endtask
  task automatic t_pin;
    for (int i = 0; i < 16; i++) begin
      lvl = 16'h0001 << i;
      tick(4);
      cmp_cap(cap, 64'h1 << (i < 4 ? CH_PIN0 + i : i < 8 ? i : CH_PIN8 + i - 8));
      lvl = 16'h0000;
      tick(3);
      clear_all();
    end
  endtask
  // A second chain pulse on a set bit must merge, so one start clears it.
  task automatic t_chain;
    chain = '1;
    tick(1);
    chain = 64'h1 << 20;
    en = 64'h8000_0001_0010_0003;
    tick(1);
    chain = '0;
    cmp_cap(cap, {64{1'b1}});
    cmp_req(req, en);
    start = 64'h0000_0000_0010_0001;
    tick(1);
    start = '0;
    cmp_cap(cap, 64'hFFFF_FFFF_FFEF_FFFE);
    en = '0;
    clear_all();
    cmp_cap(cap, 64'h0);
  endtask
  task automatic t_prio;
    for (int n = 0; n < 64; n++) prio[3*n +: 3] = n[2:0] ^ 3'h5;
    tick(1);
    cmp_prio(prio_o, prio);
  endtask
  // Set beats a same-cycle clear; a frozen block ignores events and clears alike.
  task automatic t_set_freeze;
    fire = 9'h002;
    tick(1);
    fire = 9'h000;
    clr = 64'h2;
    tick(1);
    clk_en = 1'b0;
    clr = '1;
    chain = 64'h1 << 30;
    cmp_cap(cap, 64'h2);
    tick(2);
    clk_en = 1'b1;
    chain = '0;
    cmp_cap(cap, 64'h2);
    tick(1);
    clr = '0;
    cmp_cap(cap, 64'h0);
  endtask
  // A reset in mid-run drops captures and priorities; the next cycle takes events again.
  task automatic t_reset;
    chain = 64'h1 << 40;
    tick(1);
    chain = '0;
    rst = 1'b1;
    cmp_cap(cap, 64'h1 << 40);
    tick(1);
    rst = 1'b0;
    chain = 64'h1 << 40;
    cmp_cap(cap, 64'h0);
    cmp_prio(prio_o, '0);
    tick(1);
    chain = '0;
    cmp_cap(cap, 64'h1 << 40);
    cmp_prio(prio_o, prio);
    clear_all();
  endtask
  task automatic finish_test;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    {fire, lvl, chain, en, clr, start, prio} = '0;
    clk_en = 1'b1;
    rst = 1'b1;
    n_mismatch = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    cmp_cap(cap, 64'h0);
    cmp_req(req, 64'h0);
    cmp_prio(prio_o, '0);
    t_core();
    t_pin();
    t_chain();
    t_set_freeze();
    t_prio();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire

// ==== verif/dsem_evt_src.sv ====
`timescale 1ns/100ps
`default_nettype none
// Event sources: request bits and pin levels are registered and driven out one edge later, for as long as they are held.
module dsem_evt_src (
  // Clock.
  input  wire logic        core_clk_in,
  // Requests from the bench.
  input  wire logic [8:0]  fire_in,
  input  wire logic [15:0] pin_lvl_in,
  // Event lines toward the block.
  output logic      [8:0]  evt_out,
  output logic      [15:0] pin_out
);
  initial begin
    evt_out = 9'h000;
    pin_out = 16'h0000;
  end
  always @(posedge core_clk_in) begin
    evt_out <= #1 fire_in;
    pin_out <= #1 pin_lvl_in;
  end
endmodule
`default_nettype wire
